// *** hw/ctmr_defs.vh ***
// Constants for the capture timer: modes, clock selects, timing counts
// Assumes inclusion by bare name from design files under hw/
`ifndef CTMR_DEFS_VH
`define CTMR_DEFS_VH

`define CTMR_MODE_INT 3'h0
`define CTMR_MODE_TIMEOUT 3'h1
`define CTMR_MODE_CAPTURE_IRQ 3'h2
`define CTMR_MODE_FRQ 3'h3
`define CTMR_MODE_PW 3'h4
`define CTMR_MODE_FRQPW 3'h5
`define CTMR_MODE_SINGLE 3'h6
`define CTMR_MODE_PWM8 3'h7

`define CTMR_CLK_DIV1 3'h0
`define CTMR_CLK_DIV2 3'h1
`define CTMR_CLK_WAVE 3'h2
`define CTMR_CLK_EVENT 3'h7

`define CTMR_FILTER_DEPTH 4
`define CTMR_CASCADE_DELAY 1
`define CTMR_SINGLE_START_DELAY 2'h2
`define CTMR_COUNT_MAX 16'hFFFF
`define CTMR_COUNT_RESET 16'h0000

`endif

// *** hw/ctmr_event_filter.v ***
// Four-sample noise filter for the capture event input
// Assumes the input is synchronous to clk; filter runs every clk
`timescale 1ns/10ps
`include "ctmr_defs.vh"

module ctmr_event_filter #(
    parameter DEPTH = `CTMR_FILTER_DEPTH
) (
    // Clock and reset
    clk,
    sys_rst,
    // Control
    filter_en,
    // Event in and filtered level out
    event_in,
    level_out
);
    input wire clk;
    input wire sys_rst;
    input wire filter_en;
    input wire event_in;
    output reg level_out;

    reg [DEPTH-1:0] hist_r;
    reg level_r;
    wire all_hi = &hist_r;
    wire all_lo = ~|hist_r;
    wire filt_now = all_hi | (level_r & ~all_lo);

    ////////////////////////////////////////////////////////////////////////
    // Sample history, stable level only when all samples agree
    always @(posedge clk) begin
        if (sys_rst) begin
            hist_r <= {DEPTH{1'b0}};
            level_r <= 1'b0;
        end else begin
            hist_r <= {hist_r[DEPTH-2:0], event_in};
            level_r <= filt_now;
        end
    end

    always @* begin
        if (filter_en) begin
            level_out = filt_now;
        end else begin
            level_out = event_in;
        end
    end
endmodule // ctmr_event_filter

// *** hw/ctmr_core.v ***
// Capture timer core: counter, modes, output pin, events, interrupts
// Assumes all inputs synchronous to clk; trigger_en_a single-shot edge is a raw port
//
// Function
// - PWM8 splits compare value: low byte period, high byte duty.
// - PWM8 counts zero to period; output high at zero, low at duty.
// - PWM8 high time equals duty byte; period is period byte plus one.
// - Trigger_en_a single-shot output rises at event, unsynchronised; high time longer.
// - Output enable drives waveform to pin, overriding port value.
// - Single-shot output rises at start or event, falls at stop.
// - Other modes pin level follows initial bit; disabled means no waveform.
// - Counter raises overflow event and wraps at maximum in modes other than PWM8 and single-shot.
// - Cascade bit delays capture event one peripheral clock.
// - Capture event copies count into compare/capture register in capture modes.
// - Filter keeps four samples, passes level only when all agree.
// - Filter adds four clock latency, unprescaled.
// - Waveform timer clock select counts on companion clock tick.
// - Sync restart bit restarts counter with companion restart.
// - Capture and overflow events are one-clock pulses matching flag sets.
// - Count event input clocks counter only when event source selected.
// - Clock select seven counts event rising edges; three to six reserved.
// - Capture event input enable gates capture event actions.
// - Overflow flag sets when counter wraps from maximum to zero.
// - Interrupt request while flag and enable set, until cleared.
// - Halt in standby unless run-in-standby; always halt in power-down.
// - Reading capture low byte clears capture flag in capture modes.
`timescale 1ns/10ps
`include "ctmr_defs.vh"

module ctmr_core #(
    parameter WIDTH = 16
) (
    // Clock and reset
    clk,
    sys_rst,
    // Control bits
    enable,
    run_in_standby,
    cascade_en,
    sync_restart_en,
    clock_source_sel,
    trigger_en_a,
    pin_initial_level,
    wave_out_en,
    timer_mode_sel,
    filter_en,
    edge_sel,
    capture_event_in_en,
    irq_enables,
    // Compare value write
    ccv_wr,
    ccv_wdata,
    // Count write
    cnt_wr,
    cnt_wdata,
    // Flag clear and capture low byte read
    irq_flags_wr,
    irq_flags_wdata,
    ccv_low_rd,
    // Sleep state
    sleep_standby,
    sleep_powerdown,
    // Event inputs and companion timer
    capture_event,
    capture_event_trigger_en_a,
    count_event,
    waveform_timer_tick,
    waveform_timer_restart,
    // Port output value and pin
    port_out,
    pin_out,
    pin_oe_n,
    // Status
    count_value,
    compare_capture_value,
    irq_flags,
    running,
    irq,
    capture_ev_out,
    overflow_ev_out
);
    input wire clk;
    input wire sys_rst;
    input wire enable;
    input wire run_in_standby;
    input wire cascade_en;
    input wire sync_restart_en;
    input wire [2:0] clock_source_sel;
    input wire trigger_en_a;
    input wire pin_initial_level;
    input wire wave_out_en;
    input wire [2:0] timer_mode_sel;
    input wire filter_en;
    input wire edge_sel;
    input wire capture_event_in_en;
    input wire [1:0] irq_enables;
    input wire ccv_wr;
    input wire [WIDTH-1:0] ccv_wdata;
    input wire cnt_wr;
    input wire [WIDTH-1:0] cnt_wdata;
    input wire irq_flags_wr;
    input wire [1:0] irq_flags_wdata;
    input wire ccv_low_rd;
    input wire sleep_standby;
    input wire sleep_powerdown;
    input wire capture_event;
    input wire capture_event_trigger_en_a;
    input wire count_event;
    input wire waveform_timer_tick;
    input wire waveform_timer_restart;
    input wire port_out;
    output wire pin_out;
    output wire pin_oe_n;
    output reg [WIDTH-1:0] count_value;
    output reg [WIDTH-1:0] compare_capture_value;
    output wire [1:0] irq_flags;
    output wire running;
    output wire irq;
    output reg capture_ev_out;
    output reg overflow_ev_out;

    localparam HB = WIDTH / 2;
    localparam [WIDTH-1:0] CMAX = `CTMR_COUNT_MAX;

    reg [1:0] flags_r;
    reg [1:0] flags_nxt;
    reg run_r;
    reg wave_r;
    reg div2_r;
    reg cnt_ev_d_r;
    reg filt_d_r;
    reg casc_d_r;
    reg trigger_en_a_hit_r;
    reg [1:0] ss_dly_r;
    reg [WIDTH-1:0] cnt_nxt;
    reg [WIDTH-1:0] ccv_nxt;
    reg run_nxt;
    reg wave_nxt;
    reg tick;
    reg capture_irq_set;
    reg ovf_set;
    wire active;
    wire filt_level;
    wire rise;
    wire fall;
    wire edge_now;
    wire edge_ev;
    wire start_ev;
    wire [HB-1:0] period_byte;
    wire [HB-1:0] duty_byte;
    wire is_capture_irq_mode;

    ////////////////////////////////////////////////////////////////////////
    // Event filter
    ctmr_event_filter #(
        .DEPTH(`CTMR_FILTER_DEPTH)
    ) u_filter (
        .clk(clk),
        .sys_rst(sys_rst),
        .filter_en(filter_en),
        .event_in(capture_event),
        .level_out(filt_level)
    );

    assign active = enable & ~sleep_powerdown & (~sleep_standby | run_in_standby);
    assign period_byte = compare_capture_value[HB-1:0];
    assign duty_byte = compare_capture_value[WIDTH-1:HB];
    assign is_capture_irq_mode = (timer_mode_sel >= `CTMR_MODE_CAPTURE_IRQ) && (timer_mode_sel <= `CTMR_MODE_FRQPW);

    ////////////////////////////////////////////////////////////////////////
    // Edge detection with cascade delay
    wire lvl_sel = cascade_en ? casc_d_r : filt_level;
    assign rise = lvl_sel & ~filt_d_r;
    assign fall = ~lvl_sel & filt_d_r;
    assign edge_now = edge_sel ? fall : rise;
    assign edge_ev = capture_event_in_en & active & edge_now;
    assign start_ev = (timer_mode_sel == `CTMR_MODE_SINGLE) & capture_event_in_en & active &
        (edge_sel ? (rise | fall) : rise);

    ////////////////////////////////////////////////////////////////////////
    // Clock tick select
    always @* begin
        case (clock_source_sel)
            `CTMR_CLK_DIV1: tick = 1'b1;
            `CTMR_CLK_DIV2: tick = div2_r;
            `CTMR_CLK_WAVE: tick = waveform_timer_tick;
            `CTMR_CLK_EVENT: tick = count_event & ~cnt_ev_d_r;
            default: tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter, capture and output next state
    always @* begin
        cnt_nxt = count_value;
        ccv_nxt = compare_capture_value;
        run_nxt = run_r;
        wave_nxt = wave_r;
        capture_irq_set = 1'b0;
        ovf_set = 1'b0;
        if (ccv_wr) begin
            ccv_nxt = ccv_wdata;
        end
        if (cnt_wr) begin
            cnt_nxt = cnt_wdata;
        end else if (!active) begin
            run_nxt = 1'b0;
        end else if (sync_restart_en && waveform_timer_restart) begin
            cnt_nxt = `CTMR_COUNT_RESET;
        end else begin
            case (timer_mode_sel)
                `CTMR_MODE_PWM8: begin
                    if (tick) begin
                        if (count_value[HB-1:0] == period_byte) begin
                            cnt_nxt = `CTMR_COUNT_RESET;
                            wave_nxt = 1'b1;
                            capture_irq_set = 1'b1;
                        end else begin
                            cnt_nxt = count_value + 1'b1;
                            if (count_value[HB-1:0] + 1'b1 == duty_byte) begin
                                wave_nxt = 1'b0;
                            end
                        end
                    end
                    if (count_value == `CTMR_COUNT_RESET && duty_byte == {HB{1'b0}}) begin
                        wave_nxt = 1'b0;
                    end
                end
                `CTMR_MODE_SINGLE: begin
                    if (!run_r && ss_dly_r == 2'd1) begin
                        run_nxt = 1'b1;
                        cnt_nxt = `CTMR_COUNT_RESET;
                        wave_nxt = 1'b1;
                    end else if (run_r && tick) begin
                        if (count_value == compare_capture_value) begin
                            run_nxt = 1'b0;
                            wave_nxt = 1'b0;
                            capture_irq_set = 1'b1;
                        end else begin
                            cnt_nxt = count_value + 1'b1;
                        end
                    end
                end
                default: begin
                    wave_nxt = 1'b0;
                    if (tick) begin
                        if (count_value == CMAX) begin
                            cnt_nxt = `CTMR_COUNT_RESET;
                            ovf_set = 1'b1;
                        end else if (timer_mode_sel == `CTMR_MODE_INT &&
                            count_value == compare_capture_value) begin
                            cnt_nxt = `CTMR_COUNT_RESET;
                            capture_irq_set = 1'b1;
                        end else begin
                            cnt_nxt = count_value + 1'b1;
                        end
                    end
                    if (edge_ev && is_capture_irq_mode) begin
                        ccv_nxt = count_value;
                        capture_irq_set = 1'b1;
                        if (timer_mode_sel == `CTMR_MODE_FRQ) begin
                            cnt_nxt = `CTMR_COUNT_RESET;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: set wins over clear
    always @* begin
        flags_nxt = flags_r;
        if (irq_flags_wr) begin
            flags_nxt = flags_r & ~irq_flags_wdata;
        end
        if (ccv_low_rd && is_capture_irq_mode) begin
            flags_nxt[0] = 1'b0;
        end
        if (capture_irq_set) begin
            flags_nxt[0] = 1'b1;
        end
        if (ovf_set) begin
            flags_nxt[1] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always @(posedge clk) begin
        if (sys_rst) begin
            count_value <= `CTMR_COUNT_RESET;
            compare_capture_value <= `CTMR_COUNT_RESET;
            flags_r <= 2'h0;
            run_r <= 1'b0;
            wave_r <= 1'b0;
            div2_r <= 1'b0;
            cnt_ev_d_r <= 1'b0;
            filt_d_r <= 1'b0;
            casc_d_r <= 1'b0;
            trigger_en_a_hit_r <= 1'b0;
            ss_dly_r <= 2'h0;
            capture_ev_out <= 1'b0;
            overflow_ev_out <= 1'b0;
        end else begin
            count_value <= cnt_nxt;
            compare_capture_value <= ccv_nxt;
            flags_r <= flags_nxt;
            run_r <= run_nxt;
            wave_r <= wave_nxt;
            div2_r <= active ? ~div2_r : 1'b0;
            cnt_ev_d_r <= count_event;
            filt_d_r <= lvl_sel;
            casc_d_r <= filt_level;
            capture_ev_out <= capture_irq_set;
            overflow_ev_out <= ovf_set;
            if (run_r || !active) begin
                trigger_en_a_hit_r <= 1'b0;
                ss_dly_r <= 2'h0;
            end else if (ss_dly_r != 2'h0) begin
                ss_dly_r <= ss_dly_r - 2'd1;
            end else if (start_ev || (trigger_en_a && capture_event_trigger_en_a && capture_event_in_en)) begin
                ss_dly_r <= `CTMR_SINGLE_START_DELAY;
                trigger_en_a_hit_r <= trigger_en_a;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin output
    reg wave_out;
    always @* begin
        case (timer_mode_sel)
            `CTMR_MODE_PWM8: wave_out = wave_r;
            `CTMR_MODE_SINGLE: wave_out = wave_r | (trigger_en_a & (trigger_en_a_hit_r |
                (capture_event_trigger_en_a & capture_event_in_en & active & ~run_r)));
            default: wave_out = pin_initial_level;
        endcase
    end

    assign pin_out = wave_out_en ? wave_out : port_out;
    assign pin_oe_n = ~wave_out_en;
    assign irq_flags = flags_r;
    assign running = run_r;
    assign irq = |(flags_r & irq_enables);
endmodule // ctmr_core

// *** verif/ctmr_core_props.sv ***
// Port checks for the capture timer core
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module ctmr_core_props #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Controls
    input wire enable,
    input wire sleep_powerdown,
    input wire sleep_standby,
    input wire run_in_standby,
    input wire [2:0] clock_source_sel,
    input wire [2:0] timer_mode_sel,
    input wire wave_out_en,
    input wire capture_event_in_en,
    input wire [1:0] irq_enables,
    input wire cnt_wr,
    input wire irq_flags_wr,
    input wire [1:0] irq_flags_wdata,
    input wire waveform_timer_restart,
    input wire port_out,
    // Outputs
    input wire pin_out,
    input wire pin_oe_n,
    input wire [WIDTH-1:0] count_value,
    input wire [WIDTH-1:0] compare_capture_value,
    input wire [1:0] irq_flags,
    input wire irq,
    input wire capture_ev_out,
    input wire overflow_ev_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire keep = !cnt_wr && !waveform_timer_restart;
    wire act = enable && !sleep_powerdown && (!sleep_standby || run_in_standby);
    ////////////////////////////////////////
    a_port_pass: assert property (!wave_out_en |-> pin_out == port_out && pin_oe_n)
        else $error("port value not on pin");
    a_irq_level: assert property (irq == |(irq_flags & irq_enables))
        else $error("irq does not follow flags");
    a_ovf_wrap: assert property (overflow_ev_out |-> $past(count_value) == {WIDTH{1'b1}} && irq_flags[1])
        else $error("overflow event without wrap");
    a_ovf_pulse: assert property (overflow_ev_out |=> !overflow_ev_out)
        else $error("overflow event too long");
    a_flag_clear: assert property (irq_flags_wr && irq_flags_wdata[1] ##1 !overflow_ev_out |-> !irq_flags[1])
        else $error("flag not cleared");
    a_pd_halt: assert property (sleep_powerdown && keep |=> $stable(count_value))
        else $error("count moved in power-down");
    a_sel_stop: assert property (clock_source_sel inside {[3'h3:3'h6]} && keep && !capture_event_in_en
        |=> $stable(count_value))
        else $error("count moved on reserved select");
    a_capture_irq_gate: assert property ((timer_mode_sel == 3'h2 && !capture_event_in_en) [*8] |-> !capture_ev_out)
        else $error("capture while events off");
    a_pwm_wrap: assert property (timer_mode_sel == 3'h7 && act && clock_source_sel == 3'h0 && keep
        && count_value == {8'h00, compare_capture_value[7:0]} |=> count_value == 0)
        else $error("pwm count did not wrap at period");
    a_capture_irq_event: assert property (capture_ev_out |-> irq_flags[0])
        else $error("capture event without flag");
    c_ovf: cover property (overflow_ev_out);
    c_capture_irq: cover property (capture_ev_out);
    c_pwm: cover property (timer_mode_sel == 3'h7 && pin_out);
endmodule // ctmr_core_props
bind ctmr_core ctmr_core_props #(.WIDTH(WIDTH)) u_props (.clk, .sys_rst, .enable, .sleep_powerdown,
    .sleep_standby, .run_in_standby, .clock_source_sel, .timer_mode_sel, .wave_out_en, .capture_event_in_en,
    .irq_enables, .cnt_wr, .irq_flags_wr, .irq_flags_wdata, .waveform_timer_restart, .port_out, .pin_out,
    .pin_oe_n, .count_value, .compare_capture_value, .irq_flags, .irq, .capture_ev_out, .overflow_ev_out);

// *** verif/ctmr_evt_model.sv ***
// Event network and companion timer stand-in
// Assumes the bench calls send from its main process
`timescale 1ns/10ps
module ctmr_evt_model (
    // Clock
    input wire clk,
    // Event lines
    output reg capture_event,
    output reg count_event,
    output reg waveform_timer_tick,
    output reg waveform_timer_restart
);
    initial {capture_event, count_event, waveform_timer_tick, waveform_timer_restart} = 4'h0;
    // Raises one line for hold clocks; a hold of zero raises none
    task send(input integer k, input integer hold);
        begin
            @(posedge clk);
            case (k)
                0: capture_event <= 1'b1;
                1: count_event <= 1'b1;
                2: waveform_timer_tick <= 1'b1;
                default: waveform_timer_restart <= 1'b1;
            endcase
            repeat (hold) @(posedge clk);
            {capture_event, count_event, waveform_timer_tick, waveform_timer_restart} <= 4'h0;
        end
    endtask
endmodule // ctmr_evt_model

// *** verif/timer_b_pwm_capture_output_test.sv ***
// Bench for the capture timer core
// Assumes the core, its filter and the event model are compiled
`timescale 1ns/10ps
module timer_b_pwm_capture_output_test;
    reg clk, sys_rst, enable, run_in_standby, cascade_en, sync_restart_en, trigger_en_a, pin_initial_level;
    reg wave_out_en, filter_en, edge_sel, capture_event_in_en, ccv_wr, cnt_wr, irq_flags_wr, ccv_low_rd;
    reg sleep_standby, sleep_powerdown, capture_event_trigger_en_a, port_out;
    reg [2:0] clock_source_sel, timer_mode_sel;
    reg [1:0] irq_enables, irq_flags_wdata;
    reg [15:0] ccv_wdata, cnt_wdata, c0, c1, c2;
    wire capture_event, count_event, waveform_timer_tick, waveform_timer_restart;
    wire pin_out, pin_oe_n, running, irq, capture_ev_out, overflow_ev_out;
    wire [15:0] count_value, compare_capture_value;
    wire [1:0] irq_flags;
    integer n_mismatch, samples_checked, cyc, h, i;
    ctmr_core uut (.clk, .sys_rst, .enable, .run_in_standby, .cascade_en, .sync_restart_en, .clock_source_sel,
        .trigger_en_a, .pin_initial_level, .wave_out_en, .timer_mode_sel, .filter_en, .edge_sel,
        .capture_event_in_en, .irq_enables, .ccv_wr, .ccv_wdata, .cnt_wr, .cnt_wdata, .irq_flags_wr,
        .irq_flags_wdata, .ccv_low_rd, .sleep_standby, .sleep_powerdown, .capture_event, .capture_event_trigger_en_a,
        .count_event, .waveform_timer_tick, .waveform_timer_restart, .port_out, .pin_out, .pin_oe_n,
        .count_value, .compare_capture_value, .irq_flags, .running, .irq, .capture_ev_out, .overflow_ev_out);
    ctmr_evt_model evm (.clk, .capture_event, .count_event, .waveform_timer_tick, .waveform_timer_restart);
    ////////////////////////////////////////
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
            end
        end
    endtask
    // Pulse kind k: 0 compare value, 1 count, 2 flag clear, 3 low byte read
    task wr(input integer k, input [15:0] v);
        begin
            @(posedge clk);
            ccv_wdata <= v;
            cnt_wdata <= v;
            irq_flags_wdata <= v[1:0];
            ccv_wr <= (k == 0);
            cnt_wr <= (k == 1);
            irq_flags_wr <= (k == 2);
            ccv_low_rd <= (k == 3);
            @(posedge clk);
            {ccv_wr, cnt_wr, irq_flags_wr, ccv_low_rd} <= 4'h0;
        end
    endtask
    task capture_irq(output [15:0] v);
        begin
            wr(1, 16'h0000);
            repeat (3) @(posedge clk);
            evm.send(0, 8);
            repeat (12) @(posedge clk);
            @(negedge clk);
            v = compare_capture_value;
        end
    endtask
    task dlt(output [15:0] d);
        begin
            @(negedge clk);
            d = count_value;
            repeat (5) @(posedge clk);
            @(negedge clk);
            d = count_value - d;
        end
    endtask
    task hcnt(input integer n);
        begin
            h = 0;
            for (i = 0; i < n; i = i + 1) begin
                @(negedge clk);
                h = h + pin_out;
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            end_sim;
        end
    end
    initial begin
        {enable, run_in_standby, cascade_en, sync_restart_en, trigger_en_a, pin_initial_level, wave_out_en} = 0;
        {filter_en, edge_sel, capture_event_in_en, ccv_wr, cnt_wr, irq_flags_wr, ccv_low_rd, port_out} = 0;
        {sleep_standby, sleep_powerdown, capture_event_trigger_en_a, clock_source_sel, timer_mode_sel} = 0;
        {irq_enables, irq_flags_wdata, ccv_wdata, cnt_wdata} = 0;
        {n_mismatch, samples_checked, cyc} = 0;
        sys_rst = 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk({pin_oe_n, irq, irq_flags}, 16'h0008);
        @(posedge clk);
        enable <= 1'b1;
        pin_initial_level <= 1'b1;
        wave_out_en <= 1'b1;
        repeat (2) @(negedge clk);
        chk({pin_out, pin_oe_n}, 16'h0002);
        @(posedge clk);
        wave_out_en <= 1'b0;
        @(negedge clk);
        chk({pin_out, pin_oe_n}, 16'h0001);
        $display("pin test done");
        wr(0, 16'h0204);
        @(posedge clk);
        timer_mode_sel <= 3'h7;
        wave_out_en <= 1'b1;
        wr(1, 16'h0000);
        repeat (20) @(posedge clk);
        hcnt(10);
        chk(h[15:0], 16'h0004);
        chk(pin_oe_n, 16'h0000);
        $display("pwm test done");
        @(posedge clk);
        timer_mode_sel <= 3'h2;
        wave_out_en <= 1'b0;
        irq_enables <= 2'h2;
        wr(2, 16'h0003);
        wr(1, 16'hFFFD);
        h = 0;
        for (i = 0; i < 8; i = i + 1) begin
            @(negedge clk);
            h = h + overflow_ev_out;
        end
        chk(h[15:0], 16'h0001);
        chk({irq, irq_flags}, 16'h0006);
        wr(2, 16'h0001);
        @(negedge clk);
        chk(irq_flags, 16'h0002);
        wr(2, 16'h0002);
        @(negedge clk);
        chk({irq, irq_flags}, 16'h0000);
        $display("overflow test done");
        @(posedge clk);
        capture_event_in_en <= 1'b1;
        irq_enables <= 2'h1;
        capture_irq(c0);
        chk({irq, irq_flags[0]}, 16'h0003);
        wr(3, 16'h0000);
        @(negedge clk);
        chk(irq_flags[0], 16'h0000);
        @(posedge clk);
        cascade_en <= 1'b1;
        capture_irq(c1);
        chk(c1, c0 + 16'h0001);
        @(posedge clk);
        cascade_en <= 1'b0;
        filter_en <= 1'b1;
        capture_irq(c2);
        chk(c2, c0 + 16'h0004);
        @(posedge clk);
        capture_event_in_en <= 1'b0;
        clock_source_sel <= 3'h3;
        wr(2, 16'h0003);
        evm.send(0, 8);
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk(irq_flags, 16'h0000);
        wr(1, 16'h1234);
        @(posedge clk);
        capture_event_in_en <= 1'b1;
        evm.send(0, 2);
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk(irq_flags, 16'h0000);
        evm.send(0, 8);
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk(compare_capture_value, 16'h1234);
        chk(count_value, 16'h1234);
        $display("capture test done");
        @(posedge clk);
        capture_event_in_en <= 1'b0;
        filter_en <= 1'b0;
        clock_source_sel <= 3'h7;
        wr(1, 16'h0000);
        for (i = 0; i < 5; i = i + 1)
            evm.send(1, 1);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(count_value, 16'h0005);
        @(posedge clk);
        clock_source_sel <= 3'h2;
        for (i = 0; i < 3; i = i + 1)
            evm.send(2, 1);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(count_value, 16'h0008);
        @(posedge clk);
        sync_restart_en <= 1'b1;
        evm.send(3, 1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(count_value, 16'h0000);
        $display("clock source test done");
        @(posedge clk);
        sync_restart_en <= 1'b0;
        clock_source_sel <= 3'h0;
        sleep_standby <= 1'b1;
        dlt(c0);
        chk(c0, 16'h0000);
        @(posedge clk);
        run_in_standby <= 1'b1;
        dlt(c0);
        chk(c0, 16'h0005);
        @(posedge clk);
        sleep_powerdown <= 1'b1;
        dlt(c0);
        chk(c0, 16'h0000);
        $display("sleep test done");
        @(posedge clk);
        {sleep_standby, sleep_powerdown, enable} <= 3'h0;
        timer_mode_sel <= 3'h6;
        wave_out_en <= 1'b1;
        capture_event_in_en <= 1'b1;
        wr(0, 16'h0006);
        wr(1, 16'h0006);
        @(posedge clk);
        enable <= 1'b1;
        evm.send(0, 2);
        hcnt(20);
        chk(h > 4 && h < 9, 16'h0001);
        chk({pin_out, running}, 16'h0000);
        @(posedge clk);
        trigger_en_a <= 1'b1;
        @(posedge clk);
        capture_event_trigger_en_a <= 1'b1;
        @(negedge clk);
        chk(pin_out, 16'h0001);
        evm.send(0, 2);
        capture_event_trigger_en_a <= 1'b0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk(pin_out, 16'h0000);
        $display("single-shot test done");
        end_sim;
    end
endmodule // timer_b_pwm_capture_output_test
